//--- adcpc_conv_if.sv
// Handshake between the control top and the conversion sequencer
`timescale 1ns/1ps
interface adcpc_conv_if;
    logic start;
    logic abort;
    logic busy;
    logic done;

    modport seq  (input start, input abort, output busy, output done);
    modport ctrl (output start, output abort, input busy, input done);
endinterface : adcpc_conv_if

//--- adcpc_conv_seq.sv
// Conversion phase sequencer timed from the internal clock
`timescale 1ns/1ps
module adcpc_conv_seq
    import adcpc_pkg::*;
#(
    parameter int CONV_LEN = adcpc_pkg::CONV_CYCLES
) (
    input  wire logic    i_sys_clk,
    input  wire logic    i_rst_n,
    adcpc_conv_if.seq    conv
);
    import adcpc_pkg::*;

    typedef struct packed {
        adcpc_seq_state_type    state;
        logic [CONV_CNT_W-1:0]  cnt;
        logic                   busy;
        logic                   done;
    } adcpc_seq_reg_type;

    localparam adcpc_seq_reg_type SEQ_RST = '{
        state: ADCPC_SEQ_IDLE, cnt: '0, busy: 1'b0, done: 1'b0};

    adcpc_seq_reg_type q;
    adcpc_seq_reg_type d;

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        d      = q;
        d.done = 1'b0;
        case (q.state)
            ADCPC_SEQ_IDLE: begin
                if (conv.start && !conv.abort) begin
                    d.state = ADCPC_SEQ_CONV;
                    d.cnt   = CONV_CNT_W'(CONV_LEN - 1);
                    d.busy  = 1'b1;
                end
            end
            ADCPC_SEQ_CONV: begin
                if (conv.abort) begin
                    d.state = ADCPC_SEQ_IDLE;
                    d.busy  = 1'b0;
                end else if (q.cnt == '0) begin
                    d.state = ADCPC_SEQ_IDLE;
                    d.busy  = 1'b0;
                    d.done  = 1'b1;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            default: begin
                d = SEQ_RST;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= SEQ_RST;
        end else begin
            q <= d;
        end
    end

    assign conv.busy = q.busy;
    assign conv.done = q.done;

endmodule : adcpc_conv_seq

//--- adcpc_host.sv
// Host-side driver of the start, select, read and serial clock pins
`timescale 1ns/1ps
module adcpc_host (
    input  wire logic i_sys_clk,
    output logic      o_convert_start_n,
    output logic      o_cs_n,
    output logic      o_rd_n,
    output logic      o_sdclk
);
    initial begin
        o_convert_start_n = 1'b1;
        o_cs_n            = 1'b1;
        o_rd_n            = 1'b1;
        o_sdclk           = 1'b0;
    end

    task automatic pulse_start();
        @(posedge i_sys_clk);
        o_convert_start_n <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        o_convert_start_n <= 1'b1;
        // Held high long enough that the next fall is seen
        repeat (4) @(posedge i_sys_clk);
    endtask : pulse_start

    task automatic bus_enable(input logic en);
        @(posedge i_sys_clk);
        o_cs_n <= !en;
        o_rd_n <= !en;
    endtask : bus_enable

    // Serial clock idles low between frames; levels outlast the synchroniser
    task automatic sclk_pulse();
        @(posedge i_sys_clk);
        o_sdclk <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        o_sdclk <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
    endtask : sclk_pulse
endmodule : adcpc_host

//--- adcpc_pkg.sv
// Shared constants, types and helpers for the converter control block
package adcpc_pkg;

    // Result width and bus reset value
    localparam int                 DATA_W       = 14;
    localparam logic [DATA_W-1:0]  DATA_CLEARED = 14'h0000;

    // Conversion phase length from the internal clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS  = 700;
    localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CNT_W    = 8;

    // Bus pin that carries serial data in serial mode
    localparam int SDOUT_POS = 0;

    // Positions of the pin inputs in the synchroniser vector
    localparam int PIN_CONVST_N = 0;
    localparam int PIN_SLEEP    = 1;
    localparam int PIN_RESET    = 2;
    localparam int PIN_CS_N     = 3;
    localparam int PIN_RD_N     = 4;
    localparam int PIN_SDCLK    = 5;
    localparam int PIN_REF_CORE = 6;
    localparam int PIN_REF_BUF  = 7;
    localparam int PIN_CODING   = 8;
    localparam int PIN_IF_SEL   = 9;
    localparam int PIN_IMPULSE  = 10;
    localparam int PIN_W        = 11;

    // Each sync bit resets to its pin's idle level, so no false power down
    localparam logic [PIN_W-1:0] PIN_RST = 11'h019;

    typedef enum logic [0:0] {
        ADCPC_SEQ_IDLE = 1'b0,
        ADCPC_SEQ_CONV = 1'b1
    } adcpc_seq_state_type;

    // Configuration register
    typedef struct packed {
        logic pd_by_reg;
        logic pd;
    } adcpc_cfg_type;

    localparam adcpc_cfg_type CFG_RST = '{pd_by_reg: 1'b0, pd: 1'b0};

    // Raw core code is straight binary; flipping the MSB gives twos complement
    function automatic logic [DATA_W-1:0] adcpc_format(input logic [DATA_W-1:0] code,
                                                       input logic              straight);
        adcpc_format = straight ? code : {~code[DATA_W-1], code[DATA_W-2:0]};
    endfunction : adcpc_format

endpackage : adcpc_pkg

//--- adcpc_props.sv
// Port-level properties of the converter control top
`timescale 1ns/1ps
module adcpc_props
    import adcpc_pkg::*;
#(
    parameter int CONV_LEN = 14
) (
    input wire logic                        i_sys_clk,
    input wire logic                        i_rst_n,
    input wire logic                        i_ref_core_off,
    input wire logic                        i_ref_buffer_off,
    input wire logic                        i_convert_start_n,
    input wire logic                        i_impulse_mode,
    input wire logic                        i_cs_n,
    input wire logic                        i_rd_n,
    input wire logic                        i_reset_pin,
    input wire logic                        i_cfg_load,
    input wire adcpc_pkg::adcpc_cfg_type    i_cfg_wdata,
    input wire logic                        o_ref_core_en,
    input wire logic                        o_ref_buffer_en,
    input wire logic                        o_temp_sensor_en,
    input wire logic                        o_low_power,
    input wire logic                        o_powered_down,
    input wire logic                        o_busy,
    input wire logic                        o_serial_mode,
    input wire adcpc_pkg::adcpc_cfg_type    o_cfg,
    input wire logic [adcpc_pkg::DATA_W-1:0] o_data,
    input wire logic [adcpc_pkg::DATA_W-1:0] o_data_oe
);
    logic [7:0] rp_hist_q;
    int         run_q;
    // Reset pin acts through a synchroniser, so its shadow spans 8 cycles
    wire        quiet = (rp_hist_q == 8'h00) && !i_reset_pin;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rp_hist_q <= 8'h00;
            run_q     <= 0;
        end else begin
            rp_hist_q <= {rp_hist_q[6:0], i_reset_pin};
            run_q     <= o_busy ? run_q + 1 : 0;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    ref_core_a : assert property (
        ($stable(i_ref_core_off) && !o_powered_down)[*6] |-> o_ref_core_en == !i_ref_core_off)
        else $error("reference core enable wrong");
    ref_buffer_a : assert property (
        ($stable(i_ref_buffer_off) && !o_powered_down)[*6]
        |-> o_ref_buffer_en == !i_ref_buffer_off)
        else $error("reference buffer enable wrong");
    temp_sensor_a : assert property (
        ($stable({i_ref_core_off, i_ref_buffer_off}) && !o_powered_down)[*6]
        |-> o_temp_sensor_en == !(i_ref_core_off || i_ref_buffer_off))
        else $error("temperature sensor enable wrong");
    impulse_low_a : assert property (
        (i_impulse_mode && i_convert_start_n && !o_busy && !o_powered_down && quiet)[*5]
        |-> o_low_power)
        else $error("low power missing while idle in impulse mode");
    busy_power_a : assert property (
        o_busy |-> !o_powered_down && !o_low_power)
        else $error("power reduced during conversion");
    cfg_write_a : assert property (
        i_cfg_load && quiet ##1 !i_cfg_load |-> ##1 o_cfg == $past(i_cfg_wdata, 2))
        else $error("configuration write lost");
    start_busy_a : assert property (
        $fell(i_convert_start_n) && $past(i_convert_start_n, 2) && $past(i_convert_start_n, 3)
        && !o_busy && quiet |-> ##4 o_busy)
        else $error("start edge did not begin a conversion");
    busy_len_a : assert property (
        $fell(o_busy) && quiet |-> run_q == CONV_LEN)
        else $error("conversion length wrong");
    data_hold_a : assert property (
        o_busy && !o_serial_mode && quiet |=> $stable(o_data))
        else $error("data changed during conversion");
    bus_off_a : assert property (
        (i_cs_n || i_rd_n)[*5] |=> o_data_oe == '0)
        else $error("bus driven while deselected");
    abort_a : assert property (
        $rose(i_reset_pin) ##1 i_reset_pin[*3] |=> !o_busy && o_data_oe == '0)
        else $error("reset pin did not abort");
endmodule : adcpc_props

bind adcpc_top adcpc_props #(.CONV_LEN(CONV_LEN)) u_props (.*);

//--- adcpc_top.sv
// Reference, power and conversion control with data bus drive
`timescale 1ns/1ps

// Operation
// - Core off, buffer on: internal reference off, buffer stays powered.
// - Both off pins high: reference core and buffer each powered down.
// - Temperature sensor enabled only while both off pins are low.
// - Impulse mode: low power from end of conversion through acquisition.
// - Digital interface stays fully working while impulse power scaling acts.
// - Sleep request powers down only after a running conversion ends; bus active.
// - Configuration register can select power down; sleep pin then ignored.
// - A falling edge on convert start alone begins a conversion.
// - A started conversion finishes despite further starts or sleep request.
// - Convert start acts regardless of select and read enable.
// - Result given in twos complement or straight binary per coding pin.
// - Select or read enable high puts all bus outputs in high impedance.
// - Reset pin rising edge aborts conversion and tristates the bus.
// - Reset pin falling edge clears internal state, bus and configuration.
// - Serial signals share the parallel bus pins, one style at a time.
// - Interface select low means parallel, high means serial.
module adcpc_top
    import adcpc_pkg::*;
#(
    parameter int CONV_LEN = adcpc_pkg::CONV_CYCLES
) (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_ref_core_off,
    input  wire logic                     i_ref_buffer_off,
    input  wire logic                     i_sleep_request,
    input  wire logic                     i_convert_start_n,
    input  wire logic                     i_output_coding_sel,
    input  wire logic                     i_interface_select,
    input  wire logic                     i_impulse_mode,
    input  wire logic                     i_cs_n,
    input  wire logic                     i_rd_n,
    input  wire logic                     i_reset_pin,
    input  wire logic                     i_sdclk,
    input  wire logic                     i_cfg_load,
    input  wire adcpc_pkg::adcpc_cfg_type i_cfg_wdata,
    input  wire logic [adcpc_pkg::DATA_W-1:0] i_core_code,
    output logic                          o_ref_core_en,
    output logic                          o_ref_buffer_en,
    output logic                          o_temp_sensor_en,
    output logic                          o_low_power,
    output logic                          o_powered_down,
    output logic                          o_busy,
    output logic                          o_serial_mode,
    output adcpc_pkg::adcpc_cfg_type      o_cfg,
    output logic [adcpc_pkg::DATA_W-1:0]  o_data,
    output logic [adcpc_pkg::DATA_W-1:0]  o_data_oe
);
    import adcpc_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [PIN_W-1:0]   sync1;
        logic [PIN_W-1:0]   sync2;
        logic [PIN_W-1:0]   prev;
        adcpc_cfg_type      cfg;
        logic [DATA_W-1:0]  code;
        logic               code_valid;
        logic [DATA_W-1:0]  shift;
        logic               ref_core_en;
        logic               ref_buffer_en;
        logic               temp_en;
        logic               low_power;
        logic               powered_down;
        logic               serial_mode;
        logic [DATA_W-1:0]  data;
        logic [DATA_W-1:0]  data_oe;
    } adcpc_top_reg_type;

    localparam adcpc_top_reg_type TOP_RST = '{
        sync1:         PIN_RST,
        sync2:         PIN_RST,
        prev:          PIN_RST,
        cfg:           CFG_RST,
        code:          DATA_CLEARED,
        code_valid:    1'b0,
        shift:         DATA_CLEARED,
        ref_core_en:   1'b1,
        ref_buffer_en: 1'b1,
        temp_en:       1'b1,
        low_power:     1'b0,
        powered_down:  1'b0,
        serial_mode:   1'b0,
        data:          DATA_CLEARED,
        data_oe:       DATA_CLEARED
    };

    adcpc_top_reg_type q;
    adcpc_top_reg_type d;

    adcpc_conv_if conv ();

    logic [PIN_W-1:0] pins;

    assign pins[PIN_CONVST_N] = i_convert_start_n;
    assign pins[PIN_SLEEP]    = i_sleep_request;
    assign pins[PIN_RESET]    = i_reset_pin;
    assign pins[PIN_CS_N]     = i_cs_n;
    assign pins[PIN_RD_N]     = i_rd_n;
    assign pins[PIN_SDCLK]    = i_sdclk;
    assign pins[PIN_REF_CORE] = i_ref_core_off;
    assign pins[PIN_REF_BUF]  = i_ref_buffer_off;
    assign pins[PIN_CODING]   = i_output_coding_sel;
    assign pins[PIN_IF_SEL]   = i_interface_select;
    assign pins[PIN_IMPULSE]  = i_impulse_mode;

    //////////////////////////////////////////////////////////////////////////
    // Edge helpers

    // Edge flop resets to each pin's idle level, so reset makes no false edge
    function automatic logic pin_rose(input logic [PIN_W-1:0] was_lvl,
                                      input logic [PIN_W-1:0] now_lvl,
                                      input int               pos);
        pin_rose = ~was_lvl[pos] & now_lvl[pos];
    endfunction : pin_rose

    function automatic logic pin_fell(input logic [PIN_W-1:0] was_lvl,
                                      input logic [PIN_W-1:0] now_lvl,
                                      input int               pos);
        pin_fell = was_lvl[pos] & ~now_lvl[pos];
    endfunction : pin_fell

    //////////////////////////////////////////////////////////////////////////
    // Pin decode from the second synchroniser stage only

    logic pin_core_off;
    logic pin_buf_off;
    logic pin_straight;
    logic pin_serial;
    logic pin_impulse;
    logic pin_sleep;
    logic pin_sel_n;
    logic pin_rd_n;
    logic pin_reset;
    logic start_fall;
    logic reset_rise;
    logic reset_fall;
    logic sdclk_rise;

    assign pin_core_off = q.sync2[PIN_REF_CORE];
    assign pin_buf_off  = q.sync2[PIN_REF_BUF];
    assign pin_straight = q.sync2[PIN_CODING];
    assign pin_serial   = q.sync2[PIN_IF_SEL];
    assign pin_impulse  = q.sync2[PIN_IMPULSE];
    assign pin_sleep    = q.sync2[PIN_SLEEP];
    assign pin_sel_n    = q.sync2[PIN_CS_N];
    assign pin_rd_n     = q.sync2[PIN_RD_N];
    assign pin_reset    = q.sync2[PIN_RESET];
    assign start_fall   = pin_fell(q.prev, q.sync2, PIN_CONVST_N);
    assign reset_rise   = pin_rose(q.prev, q.sync2, PIN_RESET);
    assign reset_fall   = pin_fell(q.prev, q.sync2, PIN_RESET);
    assign sdclk_rise   = pin_rose(q.prev, q.sync2, PIN_SDCLK);

    //////////////////////////////////////////////////////////////////////////
    // Conversion handshake

    assign conv.start = start_fall;
    // Level abort: a start seen while the pin is high is simply dropped
    // abort while reset held
    assign conv.abort = reset_rise | pin_reset;

    logic start_taken;
    logic conv_idle;

    // A refused start must not wake the power states for a cycle
    assign start_taken = start_fall & ~conv.abort & ~conv.busy;
    assign conv_idle   = ~conv.busy & ~start_taken;

    adcpc_conv_seq #(
        .CONV_LEN (CONV_LEN)
    ) u_conv_seq (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .conv      (conv)
    );

    //////////////////////////////////////////////////////////////////////////
    // Next state

    logic               sleep_eff;
    logic               bus_enabled;
    logic [DATA_W-1:0]  result_now;

    always_comb begin
        d       = q;
        d.sync1 = pins;
        d.sync2 = q.sync1;
        d.prev  = q.sync2;

        d.ref_core_en   = ~pin_core_off;
        d.ref_buffer_en = ~pin_buf_off;
        d.temp_en       = ~pin_core_off & ~pin_buf_off;

        d.serial_mode = pin_serial;

        // Register write is a same-clock strobe, no sync needed
        if (i_cfg_load) begin
            d.cfg = i_cfg_wdata;
        end

        sleep_eff = q.cfg.pd_by_reg ? q.cfg.pd : pin_sleep;

        d.powered_down = sleep_eff & conv_idle;

        d.low_power = pin_impulse & conv_idle;

        // Result stays readable until the next one or a reset-pin fall
        // result ready with busy low
        if (conv.done) begin
            d.code       = i_core_code;
            d.code_valid = 1'b1;
        end

        // coding applied on the way out
        result_now = q.code_valid ? adcpc_format(q.code, pin_straight) : DATA_CLEARED;

        // Reset pin keeps the bus released for as long as it is high
        // select or read high releases bus
        bus_enabled = ~pin_sel_n & ~pin_rd_n & ~pin_reset;

        // Shifts only while selected, so a stray clock cannot lose bits
        // Serial word loaded at result time, shifted MSB first
        if (conv.done) begin
            d.shift = adcpc_format(i_core_code, pin_straight);
        end else if (pin_serial && bus_enabled && sdclk_rise) begin
            d.shift = {q.shift[DATA_W-2:0], 1'b0};
        end

        // Per-pin enables let serial mode release the unused bus pins
        // serial rides on one bus pin
        if (pin_serial) begin
            d.data            = DATA_CLEARED;
            d.data[SDOUT_POS] = q.shift[DATA_W-1];
            d.data_oe         = DATA_CLEARED;
            d.data_oe[SDOUT_POS] = bus_enabled;
        end else begin
            d.data    = result_now;
            d.data_oe = {DATA_W{bus_enabled}};
        end

        if (reset_fall) begin
            d.cfg        = CFG_RST;
            d.code       = DATA_CLEARED;
            d.code_valid = 1'b0;
            d.shift      = DATA_CLEARED;
            d.data       = DATA_CLEARED;
            d.data_oe    = DATA_CLEARED;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= TOP_RST;
        end else begin
            q <= d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops

    assign o_ref_core_en    = q.ref_core_en;
    assign o_ref_buffer_en  = q.ref_buffer_en;
    assign o_temp_sensor_en = q.temp_en;
    assign o_low_power      = q.low_power;
    assign o_powered_down   = q.powered_down;
    // Busy is taken from the sequencer's flop, so it needs no copy here
    // busy from sequencer flop
    assign o_busy           = conv.busy;
    assign o_serial_mode    = q.serial_mode;
    assign o_cfg            = q.cfg;
    assign o_data           = q.data;
    assign o_data_oe        = q.data_oe;

endmodule : adcpc_top

//--- tb_top.sv
// Self-checking bench for the converter control top
`timescale 1ns/1ps
module tb_top;
    import adcpc_pkg::*;
    localparam int CL = 12;
    logic              i_sys_clk, i_rst_n, i_ref_core_off, i_ref_buffer_off, i_sleep_request;
    logic              i_output_coding_sel, i_interface_select, i_impulse_mode, i_reset_pin;
    logic              i_cfg_load, i_convert_start_n, i_cs_n, i_rd_n, i_sdclk;
    logic              o_ref_core_en, o_ref_buffer_en, o_temp_sensor_en, o_low_power;
    logic              o_powered_down, o_busy, o_serial_mode;
    adcpc_cfg_type     i_cfg_wdata, o_cfg;
    logic [DATA_W-1:0] i_core_code, o_data, o_data_oe, last_exp, word;
    logic [DATA_W-1:0] exp_q[$];
    logic [15:0]       rnd;
    int                bad_count, n_compared;

    adcpc_top #(.CONV_LEN(CL)) dut (.*);
    adcpc_host host (
        .i_sys_clk        (i_sys_clk),
        .o_convert_start_n(i_convert_start_n),
        .o_cs_n           (i_cs_n),
        .o_rd_n           (i_rd_n),
        .o_sdclk          (i_sdclk)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : wait_clk

    // Twos complement is the straight code with its top bit inverted
    task automatic convert(input logic straight, input logic push);
        rnd = lfsr(rnd);
        last_exp = straight ? rnd[13:0] : rnd[13:0] ^ 14'h2000;
        @(posedge i_sys_clk);
        i_output_coding_sel <= straight;
        i_core_code         <= rnd[13:0];
        if (push) begin
            exp_q.push_back(last_exp);
        end
        host.pulse_start();
    endtask : convert

    task automatic set_cfg(input logic by_reg, input logic pd);
        @(posedge i_sys_clk);
        i_cfg_wdata <= '{pd_by_reg: by_reg, pd: pd};
        i_cfg_load  <= 1'b1;
        @(posedge i_sys_clk);
        i_cfg_load  <= 1'b0;
        wait_clk(6);
    endtask : set_cfg

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    // Parallel result lands two edges after busy drops
    initial begin
        forever begin
            @(negedge o_busy);
            wait_clk(2);
            if (exp_q.size() > 0) begin
                check("parallel result", o_data, exp_q.pop_front());
            end
        end
    end

    initial begin
        #(3000 * 50);
        bad_count++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        {i_rst_n, i_ref_core_off, i_ref_buffer_off, i_sleep_request} = 4'h0;
        {i_output_coding_sel, i_interface_select, i_impulse_mode} = 3'h0;
        {i_reset_pin, i_cfg_load} = 2'h0;
        i_cfg_wdata = CFG_RST;
        i_core_code = '0;
        rnd = 16'h0005;
        repeat (8) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        wait_clk(6);
        check("cfg after reset", o_cfg, CFG_RST);
        for (int m = 0; m < 4; m++) begin
            @(posedge i_sys_clk);
            {i_ref_core_off, i_ref_buffer_off} <= m[1:0];
            wait_clk(6);
            check("ref core", o_ref_core_en, !m[1]);
            check("ref buffer", o_ref_buffer_en, !m[0]);
            check("temp sensor", o_temp_sensor_en, m == 0);
        end
        $display("test done: reference modes");
        check("bus idle", o_data_oe, 14'h0000);
        check("no impulse", o_low_power, 1'b0);
        host.bus_enable(1'b1);
        @(posedge i_sys_clk);
        i_impulse_mode <= 1'b1;
        wait_clk(5);
        check("bus parallel", o_data_oe, 14'h3FFF);
        for (int k = 0; k < 4; k++) begin
            convert(k[0], 1'b1);
            wait_clk(CL);
            check("impulse idle", o_low_power, 1'b1);
        end
        $display("test done: conversions");
        convert(1'b1, 1'b1);
        @(posedge i_sys_clk);
        i_sleep_request <= 1'b1;
        host.pulse_start();
        wait_clk(2);
        check("no restart", o_busy, 1'b0);
        check("sleep after conversion", o_powered_down, 1'b1);
        set_cfg(1'b1, 1'b0);
        check("sleep pin ignored", o_powered_down, 1'b0);
        @(posedge i_sys_clk);
        i_sleep_request <= 1'b0;
        set_cfg(1'b1, 1'b1);
        check("register power down", o_powered_down, 1'b1);
        $display("test done: power down");
        host.bus_enable(1'b0);
        convert(1'b0, 1'b0);
        wait_clk(1);
        check("start while deselected", o_busy, 1'b1);
        wait_clk(CL - 1);
        host.bus_enable(1'b1);
        @(posedge i_sys_clk);
        i_interface_select <= 1'b1;
        wait_clk(5);
        check("serial mode", o_serial_mode, 1'b1);
        check("serial pins", o_data_oe, 14'h0001 << SDOUT_POS);
        convert(1'b1, 1'b0);
        wait_clk(CL + 2);
        for (int b = DATA_W - 1; b >= 0; b--) begin
            word[b] = o_data[SDOUT_POS];
            host.sclk_pulse();
            #1;
        end
        check("serial word", word, last_exp);
        $display("test done: serial read");
        @(posedge i_sys_clk);
        i_interface_select <= 1'b0;
        wait_clk(5);
        convert(1'b1, 1'b0);
        @(posedge i_sys_clk);
        i_reset_pin <= 1'b1;
        wait_clk(5);
        check("abort busy", o_busy, 1'b0);
        check("abort bus", o_data_oe, 14'h0000);
        @(posedge i_sys_clk);
        i_reset_pin <= 1'b0;
        wait_clk(5);
        check("cfg cleared", o_cfg, CFG_RST);
        check("data cleared", o_data, DATA_CLEARED);
        $display("test done: reset pin");
        check("results left", 16'(exp_q.size()), 16'h0000);
        give_verdict();
    end
endmodule : tb_top
